// ===== core/uart_rx_defines.svh
// named constants of the receive data recovery block
// assumes a 40 MHz clk_in and a sample tick at 16 or 8 times the baud rate
`ifndef UART_RX_DEFINES_SVH
`define UART_RX_DEFINES_SVH
`define ADDR_W 5
`define DIV_W 12
`define OFS_CTRL 5'h00
`define OFS_DIVISOR 5'h04
`define OFS_DATA 5'h08
`define OFS_STATUS 5'h0c
`define OFS_MASK 5'h10
`define CTRL_BITS_LSB 0
`define CTRL_BITS_MSB 3
`define CTRL_PARITY 4
`define CTRL_DOUBLE 5
`define CTRL_MPCM 6
`define CTRL_W 7
`define CTRL_RESET 7'h08
`define DIVISOR_RESET 12'h000
`define DATA_FE 9
`define DATA_NINTH 8
`define EV_W 4
`define EV_DONE 0
`define EV_FRAME_ERR 1
`define EV_NOISE 2
`define EV_OVERRUN 3
`define SAMPLES_NORMAL 5'h10
`define SAMPLES_DOUBLE 5'h08
`define VOTE_FIRST_NORMAL 5'h08
`define VOTE_FIRST_DOUBLE 5'h04
`define VOTE_MID_NORMAL 5'h09
`define VOTE_MID_DOUBLE 5'h05
`define NINE_BITS 4'h9
`define MAX_BITS 10
`endif

// ===== core/uart_rx_pkg.sv
// types shared by the receive data recovery modules
// assumes nothing beyond the tool's SystemVerilog support
package uart_rx_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_START = 2'b01,
      ST_DATA = 2'b10,
      ST_GUARD = 2'b11
   } rx_state_e;
endpackage

// ===== core/rx_front_if.sv
// carrier between the sampling front end and the recovery core
// assumes both ends run on clk_in
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_defines.svh"
interface rx_front_if;
   logic [`DIV_W-1:0] divisor;
   logic sample_tick;
   logic line_level;
   modport front (input divisor, output sample_tick, output line_level);
   modport core (output divisor, input sample_tick, input line_level);
endinterface
`default_nettype wire

// ===== core/rx_sample_front.sv
// sample tick divider and three-stage line synchroniser
// assumes the receive pin is asynchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_defines.svh"
module rx_sample_front (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic serial_receive_line_in,
   rx_front_if.front fr
);
   logic [`DIV_W-1:0] div_reg;
   logic [`DIV_W-1:0] div_next;
   logic tick_reg;
   logic tick_next;
   logic [2:0] sync_reg;
   logic level_reg;
   logic level_next;

   always_comb begin
      div_next = div_reg + `DIV_W'(1);
      tick_next = 1'b0;
      if (div_reg >= fr.divisor) begin
         div_next = '0;
         tick_next = 1'b1;
      end
      // change counts once stages two and three agree
      level_next = level_reg;
      if (sync_reg[1] == sync_reg[2]) begin
         level_next = sync_reg[2];
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         div_reg <= '0;
         tick_reg <= 1'b0;
         sync_reg <= 3'h7;
         level_reg <= 1'b1;
      end else begin
         div_reg <= div_next;
         tick_reg <= tick_next;
         sync_reg <= {sync_reg[1:0], serial_receive_line_in};
         level_reg <= level_next;
      end
   end

   assign fr.sample_tick = tick_reg;
   assign fr.line_level = level_reg;
endmodule // rx_sample_front
`default_nettype wire

// ===== core/uart_rx_recovery.sv
// asynchronous receive data recovery with multi-processor filter
// assumes a register master on clk_in and a remote serial transmitter
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_defines.svh"
module uart_rx_recovery
   import uart_rx_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic serial_receive_line_in,
   input wire logic [`ADDR_W-1:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   output logic irq_out,
   output logic frame_error_flag_out
);
   import uart_rx_pkg::*;

   function automatic logic majority(input logic a, input logic b,
                                     input logic c);
      majority = (a & b) | (a & c) | (b & c);
   endfunction

   function automatic logic [8:0] keep_low(input logic [`MAX_BITS-1:0] v,
                                           input logic [3:0] n);
      logic [8:0] r;
      r = '0;
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < n) begin
            r[i] = v[i];
         end
      end
      keep_low = r;
   endfunction

   rx_front_if fif ();

   rx_sample_front u_front (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .serial_receive_line_in(serial_receive_line_in),
      .fr(fif.front)
   );

   // control and buffer registers
   logic [`CTRL_W-1:0] ctrl_reg;
   logic [`CTRL_W-1:0] ctrl_next;
   logic [`DIV_W-1:0] baud_divisor_value_reg;
   logic [`DIV_W-1:0] baud_divisor_value_next;
   logic [8:0] data_reg;
   logic [8:0] data_next;
   logic frame_error_flag_reg;
   logic frame_error_flag_next;
   logic valid_reg;
   logic valid_next;
   logic [`EV_W-1:0] status_reg;
   logic [`EV_W-1:0] status_next;
   logic [`EV_W-1:0] mask_reg;
   logic [`EV_W-1:0] mask_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   // receive machine
   rx_state_e state_reg;
   rx_state_e state_next;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic [3:0] bit_idx_reg;
   logic [3:0] bit_idx_next;
   logic [1:0] vote_reg;
   logic [1:0] vote_next;
   logic [`MAX_BITS-1:0] bits_reg;
   logic [`MAX_BITS-1:0] bits_next;
   logic prev_reg;
   logic prev_next;

   logic multiproc_filter_mode;
   logic double_speed_select;
   logic [3:0] data_bits;
   logic [3:0] total_bits;
   logic [4:0] samples;
   logic [4:0] vote_first;
   logic [4:0] vote_mid;
   logic voted;
   logic push;
   logic push_fe;
   logic push_ninth;
   logic noise_ev;
   logic pop;
   logic [`EV_W-1:0] events;

   assign multiproc_filter_mode = ctrl_reg[`CTRL_MPCM];
   assign double_speed_select = ctrl_reg[`CTRL_DOUBLE];
   assign data_bits = ctrl_reg[`CTRL_BITS_MSB:`CTRL_BITS_LSB];
   // transmit side is not in this block, the filter only gates pushes
   assign total_bits = data_bits + {3'h0, ctrl_reg[`CTRL_PARITY]};
   assign fif.divisor = baud_divisor_value_reg;

   always_comb begin
      samples = `SAMPLES_NORMAL;
      vote_first = `VOTE_FIRST_NORMAL;
      vote_mid = `VOTE_MID_NORMAL;
      if (double_speed_select) begin
         samples = `SAMPLES_DOUBLE;
         vote_first = `VOTE_FIRST_DOUBLE;
         vote_mid = `VOTE_MID_DOUBLE;
      end
   end

   // bit recovery
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      bit_idx_next = bit_idx_reg;
      vote_next = vote_reg;
      bits_next = bits_reg;
      prev_next = prev_reg;
      push = 1'b0;
      push_fe = 1'b0;
      push_ninth = 1'b0;
      noise_ev = 1'b0;
      voted = majority(vote_reg[0], vote_reg[1], fif.line_level);
      if (fif.sample_tick) begin
         prev_next = fif.line_level;
         case (state_reg)
            ST_IDLE: begin
               if (prev_reg && !fif.line_level) begin
                  // this tick is sample 1, so the next one is sample 2
                  cnt_next = 5'h02;
                  state_next = ST_START;
               end
            end
            ST_START, ST_DATA: begin
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == samples) begin
                  cnt_next = 5'h01;
                  if (state_reg == ST_START) begin
                     state_next = ST_DATA;
                     bit_idx_next = 4'h0;
                  end else begin
                     bit_idx_next = bit_idx_reg + 4'h1;
                  end
               end
               if (cnt_reg == vote_first) begin
                  vote_next[0] = fif.line_level;
               end
               if (cnt_reg == vote_mid) begin
                  vote_next[1] = fif.line_level;
               end
               if (cnt_reg == vote_mid + 5'h01) begin
                  if (state_reg == ST_START) begin
                     if (voted) begin
                        noise_ev = 1'b1;
                        state_next = ST_IDLE;
                     end
                  end else if (bit_idx_reg == total_bits) begin
                     push_fe = !voted;
                     // address frame when the type bit is one
                     push_ninth = (data_bits == `NINE_BITS) ?
                                  bits_reg[`DATA_NINTH] : voted;
                     // unselected frames are dropped
                     push = !multiproc_filter_mode || push_ninth;
                     if (double_speed_select) begin
                        state_next = ST_GUARD;
                     end else begin
                        state_next = ST_IDLE;
                     end
                  end else begin
                     bits_next[bit_idx_reg] = voted;
                  end
               end
            end
            ST_GUARD: begin
               state_next = ST_IDLE;
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 5'h00;
         bit_idx_reg <= 4'h0;
         vote_reg <= 2'h0;
         bits_reg <= '0;
         prev_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         bit_idx_reg <= bit_idx_next;
         vote_reg <= vote_next;
         bits_reg <= bits_next;
         prev_reg <= prev_next;
      end
   end

   // register file and receive buffer
   assign pop = rd_in && (addr_in == `OFS_DATA);

   always_comb begin
      events = '0;
      events[`EV_DONE] = push;
      events[`EV_FRAME_ERR] = push && push_fe;
      events[`EV_NOISE] = noise_ev;
      events[`EV_OVERRUN] = push && valid_reg && !pop;
   end

   always_comb begin
      ctrl_next = ctrl_reg;
      baud_divisor_value_next = baud_divisor_value_reg;
      mask_next = mask_reg;
      data_next = data_reg;
      frame_error_flag_next = frame_error_flag_reg;
      valid_next = valid_reg && !pop;
      rdata_next = '0;
      status_next = status_reg;
      if (wr_in) begin
         case (addr_in)
            `OFS_CTRL: ctrl_next = wdata_in[`CTRL_W-1:0];
            `OFS_DIVISOR: baud_divisor_value_next = wdata_in[`DIV_W-1:0];
            `OFS_STATUS: status_next = status_reg & ~wdata_in[`EV_W-1:0];
            `OFS_MASK: mask_next = wdata_in[`EV_W-1:0];
            default: begin
            end
         endcase
      end
      // a new event wins over a clear in the same cycle
      status_next = status_next | events;
      if (push) begin
         data_next = keep_low(bits_reg, data_bits);
         frame_error_flag_next = push_fe;
         valid_next = 1'b1;
      end
      if (rd_in) begin
         case (addr_in)
            `OFS_CTRL: rdata_next = {25'h0, ctrl_reg};
            `OFS_DIVISOR: rdata_next = {20'h0, baud_divisor_value_reg};
            `OFS_DATA: rdata_next = {21'h0, valid_reg,
                                     frame_error_flag_reg, data_reg};
            `OFS_STATUS: rdata_next = {28'h0, status_reg};
            `OFS_MASK: rdata_next = {28'h0, mask_reg};
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl_reg <= `CTRL_RESET;
         baud_divisor_value_reg <= `DIVISOR_RESET;
         data_reg <= '0;
         frame_error_flag_reg <= 1'b0;
         valid_reg <= 1'b0;
         status_reg <= '0;
         mask_reg <= '0;
         rdata_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         baud_divisor_value_reg <= baud_divisor_value_next;
         data_reg <= data_next;
         frame_error_flag_reg <= frame_error_flag_next;
         valid_reg <= valid_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_out = rdata_reg;
   assign irq_out = |(status_reg & mask_reg);
   assign frame_error_flag_out = frame_error_flag_reg;
endmodule // uart_rx_recovery
`default_nettype wire

// ===== tb/uart_rx_recovery_monitor.sv
// checker of the receive recovery block's register port
// assumes it is bound onto uart_rx_recovery
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_defines.svh"
module uart_rx_recovery_monitor (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic serial_receive_line_in,
   input wire logic [`ADDR_W-1:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic irq_out,
   input wire logic frame_error_flag_out
);
   logic [3:0] len_reg;
   logic [3:0] len_next;
   logic rd_data;
   assign rd_data = rd_in && addr_in == `OFS_DATA;
   always_comb begin
      len_next = len_reg;
      if (wr_in && addr_in == `OFS_CTRL) begin
         len_next = wdata_in[`CTRL_BITS_MSB:`CTRL_BITS_LSB];
      end
   end
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         len_reg <= 4'h8;
      end else begin
         len_reg <= len_next;
      end
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   property p_rdata_idle;
      !rd_in |=> rdata_out == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not 0");
   property p_unmapped;
      rd_in && !(addr_in inside {`OFS_CTRL, `OFS_DIVISOR, `OFS_DATA,
         `OFS_STATUS, `OFS_MASK}) |=> rdata_out == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
   property p_data_upper;
      rd_data |=> rdata_out[31:11] == 21'h0;
   endproperty
   a_data_upper: assert property (p_data_upper) else $error("data upper");
   property p_len_fill;
      rd_data |=> (rdata_out[8:0] >> len_reg) == 9'h0;
   endproperty
   a_len_fill: assert property (p_len_fill) else $error("fill bits");
   property p_fe_flag;
      rd_data |=> !rdata_out[10] ||
         rdata_out[`DATA_FE] == $past(frame_error_flag_out);
   endproperty
   a_fe_flag: assert property (p_fe_flag) else $error("fe mismatch");
   property p_mask_quiet;
      wr_in && addr_in == `OFS_MASK && wdata_in[3:0] == 4'h0 |=> !irq_out;
   endproperty
   a_mask_quiet: assert property (p_mask_quiet) else $error("irq unmasked");
   property p_irq_status;
      rd_in && addr_in == `OFS_STATUS && irq_out |=> rdata_out[3:0] != 4'h0;
   endproperty
   a_irq_status: assert property (p_irq_status) else $error("irq no status");
   property p_ctrl_back;
      wr_in && addr_in == `OFS_CTRL ##2 rd_in && addr_in == `OFS_CTRL |=>
         rdata_out[`CTRL_W-1:0] == $past(wdata_in[`CTRL_W-1:0], 3);
   endproperty
   a_ctrl_back: assert property (p_ctrl_back) else $error("ctrl");
endmodule // uart_rx_recovery_monitor
`default_nettype wire

// ===== tb/serial_sender.sv
// model of the remote serial transmitter on the receive line
// assumes each transfer starts just after a rising clk_in edge
`timescale 1ns/1ps
`default_nettype none
module serial_sender (
   input wire logic clk_in,
   output var logic line_out
);
   initial line_out = 1'b1;
   // start, bits lsb first, type or stop bit; flips two clocks at gl
   task automatic send(input logic [9:0] d, input int n, input logic stop,
      input int cpb, input int stop_len, input int gl);
      logic b;
      int t;
      t = 0;
      for (int k = 0; k <= n + 1; k++) begin
         b = (k == 0) ? 1'b0 : (k <= n) ? d[k-1] : stop;
         repeat ((k == n + 1) ? stop_len : cpb) begin
            line_out <= b ^ (t == gl || t == gl + 1);
            t++;
            @(posedge clk_in);
         end
      end
      if (!stop) begin
         line_out <= 1'b1;
      end
   endtask
   task automatic pulse(input int len);
      repeat (len) begin
         line_out <= 1'b0;
         @(posedge clk_in);
      end
      line_out <= 1'b1;
   endtask
endmodule // serial_sender
`default_nettype wire

// ===== tb/uart_rx_recovery_tb.sv
// self-checking bench of the receive recovery block
// assumes the serial_sender model and the bound monitor
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_defines.svh"
module uart_rx_recovery_tb;
   logic clk_in, sys_rst_in, wr_in, rd_in, irq_out;
   logic serial_receive_line_in, frame_error_flag_out;
   logic [`ADDR_W-1:0] addr_in;
   logic [31:0] wdata_in, rdata_out;
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   uart_rx_recovery uut (.clk_in, .sys_rst_in, .serial_receive_line_in,
      .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out,
      .frame_error_flag_out);
   serial_sender tx (.clk_in, .line_out(serial_receive_line_in));
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rc(input string what, input logic [`ADDR_W-1:0] a,
      input logic [31:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      chk(what, exp, rdata_out);
   endtask
   task automatic frame(input logic [9:0] d, input int n, input logic stop,
      input int cpb, input int gl, input logic [3:0] st,
      input logic [31:0] dat);
      @(posedge clk_in);
      tx.send(d, n, stop, cpb, cpb, gl);
      for (int i = 0; i < 24 && irq_out !== 1'b1; i++)
         @(posedge clk_in);
      rc("status", `OFS_STATUS, {28'h0, st});
      if (st[0]) begin
         rc("data", `OFS_DATA, dat);
      end
      wr(`OFS_STATUS, 32'hf);
   endtask
   task automatic s_reset();
      rc("ctrl", `OFS_CTRL, 32'h8);
      rc("divisor", `OFS_DIVISOR, 32'h0);
      rc("status", `OFS_STATUS, 32'h0);
      rc("mask", `OFS_MASK, 32'h0);
      rc("unmapped", 5'h14, 32'h0);
      chk("flags", 32'h0, {30'h0, irq_out, frame_error_flag_out});
      wr(`OFS_MASK, 32'hf);
   endtask
   task automatic s_vote();
      frame(10'h0a5, 8, 1'b1, 16, 38, 4'h1, 32'h4a5);
      frame(10'h05a, 8, 1'b1, 16, 41, 4'h1, 32'h45a);
   endtask
   task automatic s_ferr();
      frame(10'h05a, 8, 1'b0, 16, 999, 4'h3, 32'h65a);
      chk("fe", 32'h1, {31'h0, frame_error_flag_out});
   endtask
   task automatic s_double();
      wr(`OFS_CTRL, 32'h28);
      rc("ctrl", `OFS_CTRL, 32'h28);
      frame(10'h03c, 8, 1'b1, 8, 10, 4'h1, 32'h43c);
      frame(10'h0c3, 8, 1'b1, 8, 13, 4'h1, 32'h4c3);
      chk("fe", 32'h0, {31'h0, frame_error_flag_out});
      wr(`OFS_CTRL, 32'h8);
   endtask
   task automatic s_irq();
      wr(`OFS_MASK, 32'h0);
      @(posedge clk_in);
      tx.send(10'h033, 8, 1'b1, 16, 16, 999);
      repeat (24) @(posedge clk_in);
      chk("irq masked", 32'h0, {31'h0, irq_out});
      wr(`OFS_MASK, 32'h1);
      @(negedge clk_in);
      chk("irq", 32'h1, {31'h0, irq_out});
      rc("data", `OFS_DATA, 32'h433);
      wr(`OFS_STATUS, 32'h1);
      @(negedge clk_in);
      chk("irq cleared", 32'h0, {31'h0, irq_out});
      wr(`OFS_MASK, 32'hf);
   endtask
   task automatic s_len();
      wr(`OFS_CTRL, 32'h5);
      frame(10'h015, 5, 1'b1, 16, 999, 4'h1, 32'h415);
      wr(`OFS_CTRL, 32'h19);
      frame(10'h2a5, 10, 1'b1, 16, 999, 4'h1, 32'h4a5);
      wr(`OFS_CTRL, 32'h8);
   endtask
   task automatic s_noise();
      @(posedge clk_in);
      tx.pulse(8);
      repeat (24) @(posedge clk_in);
      rc("status", `OFS_STATUS, 32'h4);
      wr(`OFS_STATUS, 32'hf);
   endtask
   task automatic s_back();
      @(posedge clk_in);
      tx.send(10'h081, 8, 1'b1, 16, 10, 999);
      tx.send(10'h07e, 8, 1'b1, 16, 16, 999);
      rc("status", `OFS_STATUS, 32'h9);
      rc("data", `OFS_DATA, 32'h47e);
      wr(`OFS_STATUS, 32'hf);
   endtask
   task automatic s_mpcm();
      wr(`OFS_CTRL, 32'h49);
      frame(10'h0a5, 9, 1'b1, 16, 999, 4'h0, 32'h0);
      frame(10'h1a5, 9, 1'b1, 16, 999, 4'h1, 32'h5a5);
      wr(`OFS_CTRL, 32'h48);
      frame(10'h011, 8, 1'b0, 16, 999, 4'h0, 32'h0);
      frame(10'h022, 8, 1'b1, 16, 999, 4'h1, 32'h422);
      wr(`OFS_CTRL, 32'h9);
      frame(10'h055, 9, 1'b1, 16, 999, 4'h1, 32'h455);
   endtask
   initial begin
      sys_rst_in = 1'b1;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 5'h00;
      wdata_in = 32'h0;
      repeat (4) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      s_reset();
      s_vote();
      s_ferr();
      s_double();
      s_irq();
      s_len();
      s_noise();
      s_back();
      s_mpcm();
      report_and_stop();
   end
endmodule // uart_rx_recovery_tb
bind uart_rx_recovery uart_rx_recovery_monitor mon (.clk_in, .sys_rst_in,
   .serial_receive_line_in, .addr_in, .wdata_in, .wr_in, .rd_in,
   .rdata_out, .irq_out, .frame_error_flag_out);
`default_nettype wire
